// file: shared/sif_pkg.sv
// Constants, register map and types of the dual-channel safe input filter
package sif_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFF_PWD_ENTRY = 8'h00;
	localparam logic [7:0] OFF_PWD_NEW   = 8'h04;
	localparam logic [7:0] OFF_PWD_CONF  = 8'h08;
	localparam logic [7:0] OFF_COMM      = 8'h0C;
	localparam logic [7:0] OFF_RST_CMD   = 8'h10;
	localparam logic [7:0] OFF_ENABLE    = 8'h14;
	localparam logic [7:0] OFF_TOL       = 8'h18;
	localparam logic [7:0] OFF_DEB       = 8'h1C;
	localparam logic [7:0] OFF_ODEB      = 8'h20;
	localparam logic [7:0] OFF_STATUS    = 8'h24;
	localparam logic [7:0] OFF_IRQ_STS   = 8'h28;
	localparam logic [7:0] OFF_IRQ_MSK   = 8'h2C;
	localparam logic [7:0] OFF_TGL_LIM   = 8'h30;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int ST_STO    = 0;
	localparam int ST_UNLOCK = 1;
	localparam int ST_FA     = 2;
	localparam int ST_FB     = 3;
	localparam int ST_ORD    = 4;
	localparam int IRQ_DISC  = 0;
	localparam int IRQ_TGL   = 1;
	localparam int IRQ_STO   = 2;
	localparam int IRQ_W     = 3;

	// ---------------------------------------------------------------
	// Codes and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] PWD_DEF     = 32'h0000_0000;
	localparam logic [7:0]  COMM_READY  = 8'h00;
	localparam logic [7:0]  COMM_SAFETY = 8'h5F;
	localparam logic [7:0]  CMD_IDLE    = 8'h00;
	localparam logic [7:0]  CMD_RESET   = 8'h05;
	localparam logic [3:0]  EN_OFF      = 4'h0;
	localparam logic [3:0]  EN_BASIC    = 4'h1;
	localparam logic [15:0] TOL_MS_DEF  = 16'h01F4;
	localparam logic [7:0]  DEB_MS_DEF  = 8'h01;
	localparam logic [7:0]  ODEB_MS_DEF = 8'h01;
	localparam logic [7:0]  TGL_LIM_DEF = 8'h10;
	localparam logic [15:0] TGL_WIN_MS  = 16'h03E8;

	// ---------------------------------------------------------------
	// Timing: one millisecond tick from a 100 MHz clock
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// Safety settings restored together by the parameter reset
	typedef struct packed {
		logic [3:0]  enable;
		logic [15:0] tol_ms;
		logic [7:0]  deb_ms;
		logic [7:0]  tgl_lim;
	} sif_cfg_t;

	localparam sif_cfg_t CFG_DEF = '{enable: EN_OFF, tol_ms: TOL_MS_DEF,
		deb_ms: DEB_MS_DEF, tgl_lim: TGL_LIM_DEF};

endpackage

// file: core/sif_debounce.sv
// Millisecond debounce filter for one synchronised input level
`timescale 1ns/1ns
module sif_debounce #(
	parameter int W = 8
) (
	// Clock, reset, enable
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// Timebase and setting
	input  wire logic         tick,
	input  wire logic [W-1:0] deb_ms,
	// Level in and out
	input  wire logic         raw,
	output logic              filt
);

	logic [W-1:0] cnt_q;
	logic         last_q;

	// Output follows input only after it stood still for deb_ms ticks;
	// zero setting passes the level through two cycles later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= '0;
			last_q <= 1'b0;
			filt   <= 1'b0;
		end else if (ce) begin
			last_q <= raw;
			if (raw != last_q) begin
				cnt_q <= '0;
			end else if (raw == filt) begin
				cnt_q <= '0;
			end else if (deb_ms == '0) begin
				filt <= raw;
			end else if (tick) begin
				if (cnt_q >= deb_ms - W'(1)) begin
					filt  <= raw;
					cnt_q <= '0;
				end else begin
					cnt_q <= cnt_q + W'(1);
				end
			end
		end
	end

	// With a zero setting, a steady input level that differs from the output reaches it on the next cycle
	property p_follow;
		@(posedge aclk) disable iff (!aresetn)
		(ce && filt != raw && raw == last_q && deb_ms == '0) |=> filt == $past(raw);
	endproperty
	a_follow: assert property (p_follow)
		else $error("filter did not pass level with zero debounce");

	// A change at the input restarts the debounce time
	property p_restart;
		@(posedge aclk) disable iff (!aresetn)
		(ce && raw != last_q) |=> cnt_q == '0 && $stable(filt);
	endproperty
	a_restart: assert property (p_restart)
		else $error("debounce timer not restarted on input change");

endmodule

// file: core/sif_safe_input.sv
// Dual-channel safe input filter with AXI4-Lite register access
`timescale 1ns/1ns
module sif_safe_input #(
	parameter int TICK_CYCLES = sif_pkg::TICK_CYCLES
) (
	// Clock, reset, enable
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      ce,
	// AXI4-Lite write
	input  wire logic [sif_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read
	input  wire logic [sif_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Input pins
	input  wire logic                      fs_in_a,
	input  wire logic                      fs_in_b,
	input  wire logic                      ord_in,
	// Results
	output logic                           torque_off_active_flag,
	output logic                           ord_in_filtered,
	output logic                           irq
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [31:0]              entry_q, newpwd_q, pwd_q;
	logic [7:0]               comm_q, cmd_q, odeb_q;
	sif_pkg::sif_cfg_t        cfg_q;
	logic [sif_pkg::IRQ_W-1:0] sts_q, mask_q, sts_set;
	logic [2:0]               sync1_q, sync2_q, prev_q, filt;
	logic [TW-1:0]            tick_cnt_q;
	logic                     tick;
	logic [15:0]              dcnt_q, win_q;
	logic [7:0]               tcnt_q;
	logic                     sto_q;
	logic                     wr_fire, rd_fire, wr_ok, unlocked, safe_wr;
	logic [31:0]              wd;
	logic [32:0]              wr_cur, rd_cur;

	// Read view of every register; top bit marks a mapped address
	function automatic logic [32:0] reg_view(input logic [7:0] a);
		logic [32:0] v;
		v = {1'b1, 32'h0000_0000};
		unique case (a)
			sif_pkg::OFF_PWD_ENTRY: v[31:0] = entry_q;
			sif_pkg::OFF_PWD_NEW:   v[31:0] = newpwd_q;
			sif_pkg::OFF_PWD_CONF:  v[31:0] = 32'h0000_0000;
			sif_pkg::OFF_COMM:      v[7:0]  = comm_q;
			sif_pkg::OFF_RST_CMD:   v[7:0]  = cmd_q;
			sif_pkg::OFF_ENABLE:    v[3:0]  = cfg_q.enable;
			sif_pkg::OFF_TOL:       v[15:0] = cfg_q.tol_ms;
			sif_pkg::OFF_DEB:       v[7:0]  = cfg_q.deb_ms;
			sif_pkg::OFF_ODEB:      v[7:0]  = odeb_q;
			sif_pkg::OFF_TGL_LIM:   v[7:0]  = cfg_q.tgl_lim;
			sif_pkg::OFF_IRQ_STS:   v[sif_pkg::IRQ_W-1:0] = sts_q;
			sif_pkg::OFF_IRQ_MSK:   v[sif_pkg::IRQ_W-1:0] = mask_q;
			sif_pkg::OFF_STATUS: begin
				v[sif_pkg::ST_STO]    = sto_q;
				v[sif_pkg::ST_UNLOCK] = unlocked;
				v[sif_pkg::ST_FA]     = filt[0];
				v[sif_pkg::ST_FB]     = filt[1];
				v[sif_pkg::ST_ORD]    = filt[2];
			end
			default: v = 33'h0_0000_0000;
		endcase
		return v;
	endfunction

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------

	// Address and data are taken together, so their order does not matter
	assign wr_fire       = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign rd_fire       = ce && s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_arready = ce && !s_axi_rvalid;
	assign unlocked      = (entry_q == pwd_q);
	assign safe_wr       = unlocked && comm_q == sif_pkg::COMM_SAFETY;

	// Byte-lane merge and write acceptance
	always_comb begin
		wr_cur = reg_view(s_axi_awaddr);
		rd_cur = reg_view(s_axi_araddr);
		for (int i = 0; i < 4; i++) begin
			wd[i*8 +: 8] = s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8]
				: wr_cur[i*8 +: 8];
		end
		unique case (s_axi_awaddr)
			sif_pkg::OFF_COMM:
				wr_ok = wd[31:8] == 24'h00_0000 &&
					(wd[7:0] == sif_pkg::COMM_READY ||
					wd[7:0] == sif_pkg::COMM_SAFETY);
			sif_pkg::OFF_RST_CMD, sif_pkg::OFF_ENABLE, sif_pkg::OFF_TOL,
			sif_pkg::OFF_DEB, sif_pkg::OFF_TGL_LIM:
				wr_ok = safe_wr;
			sif_pkg::OFF_STATUS:
				wr_ok = 1'b0;
			default:
				wr_ok = wr_cur[32];
		endcase
	end

	// Write response: refused or unmapped writes answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= sif_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? sif_pkg::RESP_OKAY
					: sif_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read data registered one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= sif_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_cur[31:0];
				s_axi_rresp  <= rd_cur[32] ? sif_pkg::RESP_OKAY
					: sif_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Password and commissioning
	// ---------------------------------------------------------------

	// New password needs a matching confirm and a value of one or more
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			entry_q  <= sif_pkg::PWD_DEF;
			newpwd_q <= sif_pkg::PWD_DEF;
			pwd_q    <= sif_pkg::PWD_DEF;
			comm_q   <= sif_pkg::COMM_READY;
		end else if (ce && wr_fire && wr_ok) begin
			unique case (s_axi_awaddr)
				sif_pkg::OFF_PWD_ENTRY: entry_q  <= wd;
				sif_pkg::OFF_PWD_NEW:   newpwd_q <= wd;
				sif_pkg::OFF_PWD_CONF:
					if (unlocked && wd == newpwd_q && wd != 32'h0000_0000)
						pwd_q <= wd;
				sif_pkg::OFF_COMM:      comm_q <= wd[7:0];
				default: ;
			endcase
		end
	end

	// Reset command: one cycle to restore, then reads back idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q <= sif_pkg::CMD_IDLE;
			cfg_q <= sif_pkg::CFG_DEF;
		end else if (ce) begin
			if (cmd_q == sif_pkg::CMD_RESET) begin
				cmd_q <= sif_pkg::CMD_IDLE;
				cfg_q <= sif_pkg::CFG_DEF;
			end else if (wr_fire && wr_ok) begin
				unique case (s_axi_awaddr)
					sif_pkg::OFF_RST_CMD: cmd_q <= wd[7:0];
					sif_pkg::OFF_ENABLE:  cfg_q.enable  <= wd[3:0];
					sif_pkg::OFF_TOL:     cfg_q.tol_ms  <= wd[15:0];
					sif_pkg::OFF_DEB:     cfg_q.deb_ms  <= wd[7:0];
					sif_pkg::OFF_TGL_LIM: cfg_q.tgl_lim <= wd[7:0];
					default: ;
				endcase
			end
		end
	end

	// Ordinary debounce and mask sit outside the safety reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			odeb_q <= sif_pkg::ODEB_MS_DEF;
			mask_q <= '0;
		end else if (ce && wr_fire && wr_ok) begin
			if (s_axi_awaddr == sif_pkg::OFF_ODEB)
				odeb_q <= wd[7:0];
			if (s_axi_awaddr == sif_pkg::OFF_IRQ_MSK)
				mask_q <= wd[sif_pkg::IRQ_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Input path
	// ---------------------------------------------------------------

	// Two-stage synchronisers, plus a copy for change detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			prev_q  <= 3'h0;
		end else if (ce) begin
			sync1_q <= {ord_in, fs_in_b, fs_in_a};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// Millisecond timebase shared by every timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q <= '0;
		end else if (ce) begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + TW'(1);
		end
	end
	assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

	// Safe channels use the safe setting, the ordinary one its own
	generate
		for (genvar g = 0; g < 3; g++) begin : g_filt
			sif_debounce #(.W(8)) u_deb (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ce      (ce),
				.tick    (tick),
				.deb_ms  (g == 2 ? odeb_q : cfg_q.deb_ms),
				.raw     (sync2_q[g]),
				.filt    (filt[g])
			);
		end
	endgenerate
	assign ord_in_filtered = filt[2];

	// ---------------------------------------------------------------
	// Monitoring and reaction
	// ---------------------------------------------------------------

	// Discrepancy time, restarted whenever the channels agree again
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dcnt_q <= '0;
		end else if (ce) begin
			if (filt[0] == filt[1])
				dcnt_q <= '0;
			else if (tick && dcnt_q != 16'hFFFF)
				dcnt_q <= dcnt_q + 16'h0001;
		end
	end

	// Level changes on either safe channel counted per fixed window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win_q  <= '0;
			tcnt_q <= '0;
		end else if (ce) begin
			if (tick && win_q == sif_pkg::TGL_WIN_MS - 16'h0001) begin
				win_q  <= '0;
				tcnt_q <= '0;
			end else begin
				if (tick)
					win_q <= win_q + 16'h0001;
				if (sync2_q[1:0] != prev_q[1:0] && tcnt_q != 8'hFF)
					tcnt_q <= tcnt_q + 8'h01;
			end
		end
	end

	// Events; a set in the clearing cycle wins over the clear
	always_comb begin
		sts_set = '0;
		sts_set[sif_pkg::IRQ_DISC] = tick && filt[0] != filt[1] &&
			dcnt_q >= cfg_q.tol_ms;
		sts_set[sif_pkg::IRQ_TGL]  = tcnt_q > cfg_q.tgl_lim;
		sts_set[sif_pkg::IRQ_STO]  = !sto_q &&
			cfg_q.enable == sif_pkg::EN_BASIC && (filt[1:0] != 2'h3);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_q <= '0;
		end else if (ce) begin
			if (wr_fire && wr_ok && s_axi_awaddr == sif_pkg::OFF_IRQ_STS)
				sts_q <= (sts_q & ~wd[sif_pkg::IRQ_W-1:0]) | sts_set;
			else
				sts_q <= sts_q | sts_set;
		end
	end

	// Torque-off on the first low channel or a latched fault
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sto_q <= 1'b0;
		end else if (ce) begin
			sto_q <= cfg_q.enable == sif_pkg::EN_BASIC &&
				(!filt[0] || !filt[1] ||
				sts_q[sif_pkg::IRQ_DISC] || sts_q[sif_pkg::IRQ_TGL]);
		end
	end
	assign torque_off_active_flag = sto_q;
	assign irq = |(sts_q & mask_q);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_pwd_range;
		@(posedge aclk) disable iff (!aresetn)
		$changed(pwd_q) |-> pwd_q != 32'h0000_0000 && $past(unlocked);
	endproperty
	a_pwd_range: assert property (p_pwd_range)
		else $error("password changed to zero or while locked");

	property p_comm_legal;
		@(posedge aclk) disable iff (!aresetn)
		comm_q == sif_pkg::COMM_READY || comm_q == sif_pkg::COMM_SAFETY;
	endproperty
	a_comm_legal: assert property (p_comm_legal)
		else $error("commissioning filter holds illegal value");

	property p_cmd_clear;
		@(posedge aclk) disable iff (!aresetn)
		(ce && cmd_q == sif_pkg::CMD_RESET) |=> cmd_q == sif_pkg::CMD_IDLE
			&& cfg_q == sif_pkg::CFG_DEF;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear)
		else $error("reset command did not restore and clear");

	property p_keep_ord;
		@(posedge aclk) disable iff (!aresetn)
		(cmd_q == sif_pkg::CMD_RESET) |=> $stable(odeb_q) && $stable(pwd_q);
	endproperty
	a_keep_ord: assert property (p_keep_ord)
		else $error("safety reset touched ordinary settings");

	property p_inhibit;
		@(posedge aclk) disable iff (!aresetn)
		(ce && cfg_q.enable != sif_pkg::EN_BASIC) |=> !sto_q;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("torque-off active while functions inhibited");

	property p_select;
		@(posedge aclk) disable iff (!aresetn)
		(ce && cfg_q.enable == sif_pkg::EN_BASIC && filt[1:0] != 2'h3)
			|=> sto_q;
	endproperty
	a_select: assert property (p_select)
		else $error("low channel did not select torque-off next cycle");

	property p_disc;
		@(posedge aclk) disable iff (!aresetn)
		(ce && tick && filt[0] != filt[1] && dcnt_q >= cfg_q.tol_ms)
			|=> sts_q[sif_pkg::IRQ_DISC] ##1 sto_q ||
			cfg_q.enable != sif_pkg::EN_BASIC;
	endproperty
	a_disc: assert property (p_disc)
		else $error("persistent mismatch not reported as fault");

	property p_toggle;
		@(posedge aclk) disable iff (!aresetn)
		(ce && tcnt_q > cfg_q.tgl_lim) |=> sts_q[sif_pkg::IRQ_TGL];
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("excess toggling not reported as fault");

endmodule

// file: verification/sif_sensor_model.sv
// Behavioural two-contact safety sensor driving the safe input pair
`timescale 1ns/1ns
module sif_sensor_model #(
	parameter int MS_CYCLES = 10
) (
	// Clock
	input  wire logic aclk,
	// Contact pair, high = run
	output logic      fs_in_a,
	output logic      fs_in_b
);
	// Contacts closed at power-up; they always drive, never float
	initial begin
		fs_in_a = 1'b1;
		fs_in_b = 1'b1;
	end

	// Move both contacts right after an edge
	task automatic set_pair(input logic a, input logic b);
		@(posedge aclk);
		fs_in_a <= a;
		fs_in_b <= b;
	endtask

	// Test pulse on contact A, length in milliseconds
	task automatic pulse(input logic lvl, input int ms);
		@(posedge aclk);
		fs_in_a <= lvl;
		repeat (ms * MS_CYCLES) @(posedge aclk);
		fs_in_a <= ~lvl;
	endtask
endmodule

// file: verification/sif_safe_input_test.sv
// Self-checking bench of the dual-channel safe input filter
`timescale 1ns/1ns
module sif_safe_input_test;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int MS = 10;
	logic        aclk, aresetn, ce, ord_in, flag, ord_filt, irq, fs_a, fs_b;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          err_total, checks_done;

	// Short millisecond tick keeps the long counts quick
	sif_safe_input #(.TICK_CYCLES(MS)) dut (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .fs_in_a(fs_a),
		.fs_in_b(fs_b), .ord_in(ord_in), .torque_off_active_flag(flag),
		.ord_in_filtered(ord_filt), .irq(irq));

	sif_sensor_model #(.MS_CYCLES(MS)) sensor (.aclk(aclk), .fs_in_a(fs_a),
		.fs_in_b(fs_b));

	// 100 MHz clock
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Address and data offered together, held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = 2'h0);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata & m, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// Bounded wait for the torque-off flag
	task automatic wait_flag(input logic v, input int lim);
		int n;
		n = 0;
		while (flag !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk({31'h0, flag}, {31'h0, v});
	endtask

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Whole run needs under 4000 cycles; a hang ends here
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		report_and_stop;
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, ord_in} = '0;
		{awaddr, araddr, wdata} = '0;
		ce = 1'b1;
		wstrb = 4'hF;
		err_total = 0;
		checks_done = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// Factory settings and map edges
		rd(sif_pkg::OFF_ENABLE, 32'h0);
		rd(sif_pkg::OFF_TOL, 32'h1F4);
		rd(sif_pkg::OFF_DEB, 32'h1);
		rd(sif_pkg::OFF_PWD_ENTRY, 32'h0);
		rd(sif_pkg::OFF_STATUS, 32'h2, 32'h3);
		rd(8'h3C, 32'h0, 32'hFFFF_FFFF, 2'h2);
		wr(sif_pkg::OFF_STATUS, 32'h1, 2'h2);
		// Safety writes only in safety commissioning
		wr(sif_pkg::OFF_ENABLE, 32'h1, 2'h2);
		wr(sif_pkg::OFF_COMM, 32'h7, 2'h2);
		wr(sif_pkg::OFF_COMM, 32'h5F);
		rd(sif_pkg::OFF_COMM, 32'h5F);
		wr(sif_pkg::OFF_ENABLE, 32'h1);
		wr(sif_pkg::OFF_DEB, 32'h6);
		wr(sif_pkg::OFF_ODEB, 32'h1E);
		repeat (20 * MS) @(posedge aclk);
		chk({31'h0, flag}, 32'h0);
		ord_in <= 1'b1;
		// A 4 ms off test stays below the 6 ms debounce
		sensor.pulse(1'b0, 4);
		repeat (2 * MS) @(posedge aclk);
		chk({31'h0, flag}, 32'h0);
		// Falling contact: torque-off after debounce, not tolerance
		sensor.set_pair(1'b0, 1'b1);
		repeat (45) @(posedge aclk);
		chk({31'h0, flag}, 32'h0);
		wait_flag(1'b1, 40);
		chk({31'h0, ord_filt}, 32'h0);
		rd(sif_pkg::OFF_STATUS, 32'h1, 32'h1);
		rd(sif_pkg::OFF_IRQ_STS, 32'h4, 32'h5);
		chk({31'h0, irq}, 32'h0);
		wr(sif_pkg::OFF_IRQ_MSK, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wr(sif_pkg::OFF_IRQ_STS, 32'h4);
		chk({31'h0, irq}, 32'h0);
		// Lasting mismatch beyond a 3 ms tolerance
		wr(sif_pkg::OFF_TOL, 32'h3);
		sensor.set_pair(1'b1, 1'b0);
		repeat (15 * MS) @(posedge aclk);
		rd(sif_pkg::OFF_IRQ_STS, 32'h1, 32'h1);
		// New password locks, entry unlocks, zero is refused
		wr(sif_pkg::OFF_PWD_NEW, 32'h0000_ABCD);
		wr(sif_pkg::OFF_PWD_CONF, 32'h0000_ABCD);
		rd(sif_pkg::OFF_STATUS, 32'h0, 32'h2);
		wr(sif_pkg::OFF_TOL, 32'h1F4, 2'h2);
		wr(sif_pkg::OFF_PWD_ENTRY, 32'h0000_ABCD);
		wr(sif_pkg::OFF_PWD_NEW, 32'h0);
		wr(sif_pkg::OFF_PWD_CONF, 32'h0);
		rd(sif_pkg::OFF_STATUS, 32'h2, 32'h2);
		wr(sif_pkg::OFF_TOL, 32'h1F4);
		// Too many level changes in the window
		// Limit above the changes seen so far, so only the loop trips it
		wr(sif_pkg::OFF_TGL_LIM, 32'h7);
		rd(sif_pkg::OFF_IRQ_STS, 32'h0, 32'h2);
		repeat (3) begin
			sensor.set_pair(1'b0, 1'b0);
			repeat (8 * MS) @(posedge aclk);
			sensor.set_pair(1'b1, 1'b1);
			repeat (8 * MS) @(posedge aclk);
		end
		rd(sif_pkg::OFF_IRQ_STS, 32'h2, 32'h2);
		chk({31'h0, ord_filt}, 32'h1);
		// Parameter reset restores safety settings only
		wr(sif_pkg::OFF_RST_CMD, 32'h5);
		repeat (4) @(posedge aclk);
		rd(sif_pkg::OFF_RST_CMD, 32'h0);
		rd(sif_pkg::OFF_ENABLE, 32'h0);
		rd(sif_pkg::OFF_TOL, 32'h1F4);
		rd(sif_pkg::OFF_DEB, 32'h1);
		rd(sif_pkg::OFF_TGL_LIM, 32'h10);
		rd(sif_pkg::OFF_ODEB, 32'h1E);
		rd(sif_pkg::OFF_COMM, 32'h5F);
		wait_flag(1'b0, 5);
		// Operator power cycle after the reset; factory state returns
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(sif_pkg::OFF_STATUS, 32'h2, 32'h3);
		rd(sif_pkg::OFF_IRQ_STS, 32'h0);
		// Zero ordinary debounce passes a level within a few clocks
		repeat (3 * MS) @(posedge aclk);
		chk({31'h0, ord_filt}, 32'h1);
		wr(sif_pkg::OFF_ODEB, 32'h0);
		ord_in <= 1'b0;
		repeat (6) @(posedge aclk);
		chk({31'h0, ord_filt}, 32'h0);
		report_and_stop;
	end
endmodule
